// [qee_ctl_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// External controller driving A/B pins
// ----------------------------------------
module qee_ctl_model (
   input  wire logic clk,
   output logic      a,
   output logic      b
);
   logic [1:0] ph;
   initial begin
      a = 1'b0;
      b = 1'b0;
      ph = 2'h0;
   end
   // Each level held 4 clocks so no edge is missed
   task automatic hold();
      repeat (4) @(posedge clk);
   endtask
   // Kind 0 gray A/B, 1 step/direction, 2 up/down
   task automatic act(input int m, input int n, input bit dn);
      for (int i = 0; i < n; i++) begin
         if (m == 0) begin
            ph = dn ? ph - 2'h1 : ph + 2'h1;
            a <= ph[1] ^ ph[0];
            b <= ph[1];
         end else if (m == 1) begin
            b <= dn;
            hold();
            a <= 1'b1;
         end else if (dn) begin
            b <= 1'b1;
         end else begin
            a <= 1'b1;
         end
         hold();
         if (m != 0) begin
            a <= 1'b0;
            b <= (m == 1) ? dn : 1'b0;
         end
         hold();
      end
      // B back low while A is low for kinds 1 and 2, kind 0 keeps B at ph[1], so no count
      b <= (m == 0) ? ph[1] : 1'b0;
      hold();
   endtask
endmodule

// [qee_pkg.sv]
package qee_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int         ADDR_W         = 8;
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_EMU_RES    = 8'h04;
   localparam logic [7:0] OFS_IDX_OFS    = 8'h08;
   localparam logic [7:0] OFS_ABS_TURNS  = 8'h0C;
   localparam logic [7:0] OFS_FULL_OFS   = 8'h10;
   localparam logic [7:0] OFS_SEC_RES    = 8'h14;
   localparam logic [7:0] OFS_SEC_POS    = 8'h18;
   localparam logic [7:0] OFS_EMU_COUNT  = 8'h1C;

   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam int          CTRL_W        = 7;
   localparam int          FRAC_W        = 16;
   localparam logic [15:0] RES_RST       = 16'h0000;
   localparam logic [15:0] IDX_OFS_RST   = 16'h0000;
   localparam logic [15:0] TURNS_RST     = 16'h0000;

   typedef enum logic [1:0] {
      EMU_INPUT    = 2'h0,
      EMU_PER_REV  = 2'h1,
      EMU_ABSOLUTE = 2'h2,
      EMU_RSVD     = 2'h3
   } qee_emu_mode_t;

   typedef enum logic [1:0] {
      SRC_NONE     = 2'h0,
      SRC_EMU_CONN = 2'h1,
      SRC_OPTO     = 2'h2,
      SRC_RSVD     = 2'h3
   } qee_sec_src_t;

   typedef enum logic [1:0] {
      SEC_QUAD     = 2'h0,
      SEC_STEP_DIR = 2'h1,
      SEC_UP_DOWN  = 2'h2,
      SEC_RSVD     = 2'h3
   } qee_sec_mode_t;

   // Bits 6, 5:4, 3:2, 1:0 of the control word
   typedef struct packed {
      logic          dir_inv;
      qee_sec_mode_t sec_mode;
      qee_sec_src_t  sec_src;
      qee_emu_mode_t emu_mode;
   } qee_ctrl_t;

   localparam qee_ctrl_t CTRL_RST = qee_ctrl_t'(7'h00);

endpackage

// [qee_top.sv]
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Secondary source 0 none, 1 emulation connector, 2 opto input connector.
// - Secondary decode 0 A/B quadrature, 1 step/direction, 2 up/down.
// - Secondary resolution sets counts per secondary revolution.
// - Emulation mode 0 drives nothing; emulation connector is an input.
// - Mode 1 outputs quadrature with index once per revolution.
// - Mode 2 outputs quadrature with index at one absolute position.
// - Emulated pulses follow measured motor position.
// - Outputs A, B, index; A and B a quarter cycle apart.
// - Emulation resolution sets output counts per primary revolution.
// - Index offset scaled one revolution = 65536, independent of resolution.
// - Per-revolution index fires at the index offset angle each turn.
// - Absolute index fires at turns plus fractional offset.
// - Full offset is computed and read-only.
// - Offset in use follows selected emulation mode.
// - Direction setting maps motor direction onto output sense.
// - Resolution counts are post-quadrature edges, four per line.
// - Resolution zero produces no counts.
module qee_top
   import qee_pkg::*;
#(
   parameter int RES_W = 16,
   parameter int POS_W = 32
)(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [POS_W-1:0]  motor_pos,
   input  wire logic              emu_a_i,
   input  wire logic              emu_b_i,
   output logic                   emu_a_o,
   output logic                   emu_b_o,
   output logic                   emu_z_o,
   output logic                   emu_oe,
   input  wire logic              opto_a_i,
   input  wire logic              opto_b_i
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Position in turns.fraction times counts per turn
   function automatic logic signed [31:0] scale(input logic signed [31:0] p,
                                                 input logic [RES_W-1:0] r);
      logic signed [48:0] m;
      m = p * $signed({1'b0, r});
      return m[47:16];
   endfunction

   // Counter inside one revolution, wraps at r
   function automatic logic [RES_W-1:0] wrap(input logic [RES_W-1:0] v,
                                             input logic [RES_W-1:0] r,
                                             input logic up,
                                             input logic dn);
      logic [RES_W-1:0] top;
      top = r - 1'b1;
      if (up)
         return (v >= top) ? '0 : v + 1'b1;
      else if (dn)
         return (v == '0) ? top : v - 1'b1;
      else
         return v;
   endfunction

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------
   qee_ctrl_t              ctrl_r;
   logic [RES_W-1:0]       emu_res_r;
   logic [FRAC_W-1:0]      idx_ofs_r;
   logic [15:0]            abs_turn_r;
   logic [RES_W-1:0]       sec_res_r;
   logic [ADDR_W-1:0]      addr_r;
   logic                   wr_r;
   logic                   rd_r;
   logic signed [31:0]     out_cnt_r;
   logic [RES_W-1:0]       rev_cnt_r;
   logic [RES_W-1:0]       sec_pos_r;
   logic [15:0]            sec_turn_r;

   wire        take      = hsel & hready & htrans[1];
   wire        wr_ctrl   = wr_r & (addr_r == OFS_CTRL);
   wire        wr_res    = wr_r & (addr_r == OFS_EMU_RES);
   wire        wr_idx    = wr_r & (addr_r == OFS_IDX_OFS);
   wire        wr_turns  = wr_r & (addr_r == OFS_ABS_TURNS);
   wire        wr_sres   = wr_r & (addr_r == OFS_SEC_RES);
   wire [31:0] full_ofs  = {abs_turn_r, idx_ofs_r};
   wire [31:0] rd_mux    =
      (addr_r == OFS_CTRL)      ? {25'h0, ctrl_r} :
      (addr_r == OFS_EMU_RES)   ? 32'(emu_res_r) :
      (addr_r == OFS_IDX_OFS)   ? 32'(idx_ofs_r) :
      (addr_r == OFS_ABS_TURNS) ? 32'(abs_turn_r) :
      (addr_r == OFS_FULL_OFS)  ? full_ofs :
      (addr_r == OFS_SEC_RES)   ? 32'(sec_res_r) :
      (addr_r == OFS_SEC_POS)   ? {sec_turn_r, 16'(sec_pos_r)} :
      (addr_r == OFS_EMU_COUNT) ? out_cnt_r : 32'h0000_0000;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rd_r ? rd_mux : 32'h0000_0000;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_r <= '0;
         wr_r   <= 1'b0;
         rd_r   <= 1'b0;
      end else begin
         wr_r <= take & hwrite;
         rd_r <= take & ~hwrite;
         if (take) begin
            addr_r <= haddr[ADDR_W-1:0];
         end
      end
   end

   // Full offset has no write strobe at all
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r     <= CTRL_RST;
         emu_res_r  <= RES_RST;
         idx_ofs_r  <= IDX_OFS_RST;
         abs_turn_r <= TURNS_RST;
         sec_res_r  <= RES_RST;
      end else begin
         if (wr_ctrl)  ctrl_r     <= qee_ctrl_t'(hwdata[CTRL_W-1:0]);
         if (wr_res)   emu_res_r  <= hwdata[RES_W-1:0];
         if (wr_idx)   idx_ofs_r  <= hwdata[FRAC_W-1:0];
         if (wr_turns) abs_turn_r <= hwdata[15:0];
         if (wr_sres)  sec_res_r  <= hwdata[RES_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Encoder emulation output
   // ---------------------------------------------------------------
   wire out_active = (ctrl_r.emu_mode == EMU_PER_REV) |
                     (ctrl_r.emu_mode == EMU_ABSOLUTE);
   wire signed [31:0] target   = scale($signed(motor_pos), emu_res_r);
   wire signed [31:0] idx_full = scale($signed({16'h0, idx_ofs_r}), emu_res_r);
   wire signed [31:0] full_cnt = scale($signed(full_ofs), emu_res_r);
   wire [RES_W-1:0]   idx_cnt  = idx_full[RES_W-1:0];
   wire res_ok  = (emu_res_r != '0);
   wire step_up = out_active & res_ok & (target > out_cnt_r);
   wire step_dn = out_active & res_ok & (target < out_cnt_r);
   // One quadrature edge per count, so a line gives four counts
   wire [1:0] cnt_ph = out_cnt_r[1:0];
   wire [1:0] phase  = ctrl_r.dir_inv ? 2'(2'h0 - cnt_ph) : cnt_ph;
   // Gray sequence 00,10,11,01 on (A,B): A leads when counting up
   wire a_nxt = out_active & (phase[1] ^ phase[0]);
   wire b_nxt = out_active & phase[1];
   // Offset applies per mode; held while the count stays at the hit
   wire z_hit = (ctrl_r.emu_mode == EMU_PER_REV)  ? (rev_cnt_r == idx_cnt) :
                (ctrl_r.emu_mode == EMU_ABSOLUTE) ? (out_cnt_r == full_cnt) :
                1'b0;
   wire signed [31:0] out_cnt_nxt = step_up ? out_cnt_r + 32'sd1 :
                                    step_dn ? out_cnt_r - 32'sd1 : out_cnt_r;

   // Catch-up rate is one count per clock; fast moves lag briefly
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_cnt_r <= '0;
         rev_cnt_r <= '0;
         emu_a_o   <= 1'b0;
         emu_b_o   <= 1'b0;
         emu_z_o   <= 1'b0;
         emu_oe    <= 1'b0;
      end else begin
         out_cnt_r <= out_cnt_nxt;
         rev_cnt_r <= wrap(rev_cnt_r, emu_res_r, step_up, step_dn);
         emu_a_o   <= a_nxt;
         emu_b_o   <= b_nxt;
         emu_z_o   <= out_active & z_hit;
         emu_oe    <= out_active;
      end
   end

   // ---------------------------------------------------------------
   // Secondary position input
   // ---------------------------------------------------------------
   logic prev_a_r;
   logic prev_b_r;

   // Emulation pins only count as input while the output is off
   wire sel_a = (ctrl_r.sec_src == SRC_EMU_CONN) ? (emu_a_i & ~out_active) :
                (ctrl_r.sec_src == SRC_OPTO)     ? opto_a_i : 1'b0;
   wire sel_b = (ctrl_r.sec_src == SRC_EMU_CONN) ? (emu_b_i & ~out_active) :
                (ctrl_r.sec_src == SRC_OPTO)     ? opto_b_i : 1'b0;
   wire [1:0] g_cur  = {sel_b, sel_a ^ sel_b};
   wire [1:0] g_prev = {prev_b_r, prev_a_r ^ prev_b_r};
   wire rise_a = sel_a & ~prev_a_r;
   wire rise_b = sel_b & ~prev_b_r;
   wire q_up  = (g_cur == 2'(g_prev + 2'h1));
   wire q_dn  = (g_prev == 2'(g_cur + 2'h1));
   wire src_on = (ctrl_r.sec_src == SRC_EMU_CONN) | (ctrl_r.sec_src == SRC_OPTO);
   wire sec_go = src_on & (sec_res_r != '0);
   wire sec_up = sec_go & ((ctrl_r.sec_mode == SEC_QUAD)     ? q_up :
                           (ctrl_r.sec_mode == SEC_STEP_DIR) ? (rise_a & ~sel_b) :
                           (ctrl_r.sec_mode == SEC_UP_DOWN)  ? (rise_a & ~rise_b) : 1'b0);
   wire sec_dn = sec_go & ((ctrl_r.sec_mode == SEC_QUAD)     ? q_dn :
                           (ctrl_r.sec_mode == SEC_STEP_DIR) ? (rise_a & sel_b) :
                           (ctrl_r.sec_mode == SEC_UP_DOWN)  ? (rise_b & ~rise_a) : 1'b0);
   wire sec_wrap_up = sec_up & (sec_pos_r >= sec_res_r - 1'b1);
   wire sec_wrap_dn = sec_dn & (sec_pos_r == '0);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_a_r   <= 1'b0;
         prev_b_r   <= 1'b0;
         sec_pos_r  <= '0;
         sec_turn_r <= '0;
      end else begin
         prev_a_r   <= sel_a;
         prev_b_r   <= sel_b;
         sec_pos_r  <= wrap(sec_pos_r, sec_res_r, sec_up, sec_dn);
         sec_turn_r <= sec_wrap_up ? sec_turn_r + 16'h0001 :
                       sec_wrap_dn ? sec_turn_r - 16'h0001 : sec_turn_r;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_input_mode_quiet: assert property (
      @(posedge clk) disable iff (!nrst)
      (ctrl_r.emu_mode == EMU_INPUT) |=> !emu_oe && !emu_z_o && !emu_a_o)
      else $error("Emulation output active in input mode");

   a_quad_one_edge: assert property (
      @(posedge clk) disable iff (!nrst)
      emu_oe && $past(emu_oe) && $stable(ctrl_r) && ($past(ctrl_r) == $past(ctrl_r, 2))
      |-> !($changed(emu_a_o) && $changed(emu_b_o)))
      else $error("A and B changed together");

   a_res_zero_hold: assert property (
      @(posedge clk) disable iff (!nrst)
      (emu_res_r == '0) |=> $stable(out_cnt_r))
      else $error("Counts emitted with zero resolution");

   a_track_up: assert property (
      @(posedge clk) disable iff (!nrst)
      out_active && res_ok && (target > out_cnt_r)
      |=> out_cnt_r == $past(out_cnt_r) + 32'sd1)
      else $error("Output count did not follow motor position");

   a_fwd_a_leads: assert property (
      @(posedge clk) disable iff (!nrst)
      step_up && !ctrl_r.dir_inv && (cnt_ph == 2'h0) && $stable(ctrl_r)
      ##1 $stable(ctrl_r) |=> emu_a_o && !emu_b_o)
      else $error("A does not lead B in forward motion");

   a_rev_index: assert property (
      @(posedge clk) disable iff (!nrst)
      (ctrl_r.emu_mode == EMU_PER_REV) && (rev_cnt_r == idx_cnt) |=> emu_z_o)
      else $error("Per-revolution index missed");

   a_abs_index: assert property (
      @(posedge clk) disable iff (!nrst)
      (ctrl_r.emu_mode == EMU_ABSOLUTE) && (out_cnt_r != full_cnt) |=> !emu_z_o)
      else $error("Absolute index away from full offset");

   a_full_readonly: assert property (
      @(posedge clk) disable iff (!nrst)
      rd_r && (addr_r == OFS_FULL_OFS) |-> hrdata == {abs_turn_r, idx_ofs_r})
      else $error("Full offset read mismatch");

   a_no_source_hold: assert property (
      @(posedge clk) disable iff (!nrst)
      (ctrl_r.sec_src == SRC_NONE) |=> $stable(sec_pos_r) && $stable(sec_turn_r))
      else $error("Secondary counted with no source");

endmodule

// [quadrature_encoder_emulation_test.sv]
`timescale 1ns/1ps
module quadrature_encoder_emulation_test;
   import qee_pkg::*;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic        clk, nrst, hsel, hwrite;
   logic [31:0] haddr, hwdata, motor_pos, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, a_o, b_o, z_o, oe;
   wire  logic  ea, eb, oa, ob;
   wire  logic  hready;
   int          miscompares, cmp_count;
   assign hready = hreadyout;
   qee_top uut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .motor_pos(motor_pos), .emu_a_i(ea),
      .emu_b_i(eb), .emu_a_o(a_o), .emu_b_o(b_o), .emu_z_o(z_o), .emu_oe(oe),
      .opto_a_i(oa), .opto_b_i(ob));
   qee_ctl_model p_emu (.clk(clk), .a(ea), .b(eb));
   qee_ctl_model p_opto (.clk(clk), .a(oa), .b(ob));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h00000000, q);
      chk(q, e);
   endtask
   // Catch-up is one count a clock; 10 clocks covers every move below
   task automatic mv(input logic [31:0] p);
      motor_pos <= p;
      repeat (10) @(posedge clk);
   endtask
   // Pins packed as {oe, A, B, index}
   task automatic pc(input logic [3:0] e);
      chk({28'h0000000, oe, a_o, b_o, z_o}, {28'h0000000, e});
   endtask
   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
   endtask
   task automatic results();
      if (miscompares == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 9; i++) rc(8'(4 * i), 32'h00000000);
      pc(4'h0);
      chk({30'h0, hreadyout, hresp}, 32'h00000002);
   endtask
   task automatic t_regs();
      wr(OFS_CTRL, 32'hFFFFFFFF);
      rc(OFS_CTRL, 32'h0000007F);
      wr(OFS_ABS_TURNS, 32'h00000001);
      wr(OFS_IDX_OFS, 32'h00008000);
      wr(OFS_FULL_OFS, 32'h12345678);
      rc(OFS_FULL_OFS, 32'h00018000);
      wr(OFS_CTRL, 32'h00000000);
   endtask
   task automatic t_emu();
      wr(OFS_EMU_RES, 32'h00000004);
      mv(32'h00010000);
      pc(4'h0);
      rc(OFS_EMU_COUNT, 32'h00000000);
      wr(OFS_CTRL, 32'h00000001);
      mv(32'h00010000);
      pc(4'h8);
      rc(OFS_EMU_COUNT, 32'h00000004);
      mv(32'h00014000);
      pc(4'hC);
      mv(32'h00018000);
      pc(4'hF);
      mv(32'h0001C000);
      pc(4'hA);
      mv(32'h00014000);
      pc(4'hC);
      wr(OFS_CTRL, 32'h00000041);
      mv(32'h00014000);
      pc(4'hA);
      wr(OFS_CTRL, 32'h00000001);
      wr(OFS_EMU_RES, 32'h00000000);
      mv(32'h00030000);
      rc(OFS_EMU_COUNT, 32'h00000005);
      wr(OFS_EMU_RES, 32'h00000004);
      wr(OFS_CTRL, 32'h00000002);
      mv(32'h00018000);
      pc(4'hF);
      mv(32'h00028000);
      pc(4'hE);
      // Same offset at double resolution lands on count 12
      wr(OFS_EMU_RES, 32'h00000008);
      mv(32'h00018000);
      pc(4'h9);
      wr(OFS_CTRL, 32'h00000000);
      mv(32'h00018000);
      pc(4'h0);
   endtask
   task automatic sec(input logic [31:0] c, input int m, input int n, input bit dn,
                      input bit opto, input logic [31:0] e);
      do_reset();
      wr(OFS_SEC_RES, 32'h00000004);
      wr(OFS_CTRL, c);
      if (opto) p_opto.act(m, n, dn);
      else p_emu.act(m, n, dn);
      rc(OFS_SEC_POS, e);
   endtask
   task automatic t_sec();
      sec(32'h00000008, 0, 8, 1'b0, 1'b1, 32'h00020000);
      sec(32'h00000008, 0, 4, 1'b1, 1'b1, 32'hFFFF0000);
      sec(32'h00000004, 0, 4, 1'b0, 1'b0, 32'h00010000);
      sec(32'h00000008, 0, 4, 1'b0, 1'b0, 32'h00000000);
      sec(32'h00000000, 0, 4, 1'b0, 1'b1, 32'h00000000);
      sec(32'h00000018, 1, 2, 1'b0, 1'b1, 32'h00000002);
      sec(32'h00000018, 1, 1, 1'b1, 1'b1, 32'hFFFF0003);
      sec(32'h00000024, 2, 3, 1'b0, 1'b0, 32'h00000003);
      sec(32'h00000028, 2, 1, 1'b1, 1'b1, 32'hFFFF0003);
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      miscompares = 0;
      cmp_count = 0;
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      motor_pos = 32'h00000000;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_regs();
      t_emu();
      t_sec();
      results();
   end
   // Whole run needs well under 5000 clocks
   initial begin
      #2000000;
      miscompares++;
      results();
   end
endmodule
